// File: hw/tws_defines.svh
// Shared constants for the two-wire serial memory link
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
`define TWS_DEV_TYPE 4'ha
`define TWS_MEM_BYTES 512
`define TWS_PAGE_BITS_SMALL 3
`define TWS_PAGE_BITS_LARGE 4
`define TWS_WR_TIME_NS 5000000
`define TWS_CLK_NS 5
`define TWS_WR_CYCLES (`TWS_WR_TIME_NS / `TWS_CLK_NS)
`define TWS_SCL_HALF 8'h0a
`endif

// File: hw/tws_pkg.sv
// Types shared by both ends of the two-wire serial memory link
package tws_pkg;
    typedef enum logic [6:0] {
        TWS_IDLE = 7'h01,
        TWS_DADDR = 7'h02,
        TWS_WADDR = 7'h04,
        TWS_WDATA = 7'h08,
        TWS_RDATA = 7'h10,
        TWS_RACK = 7'h20,
        TWS_SKIP = 7'h40
    } tws_state_e;
    typedef enum logic [5:0] {
        TWH_IDLE = 6'h01,
        TWH_START = 6'h02,
        TWH_BIT = 6'h04,
        TWH_ACK = 6'h08,
        TWH_STOP = 6'h10,
        TWH_DONE = 6'h20
    } tws_host_e;
endpackage : tws_pkg

// File: hw/tws_link_if.sv
// Two-wire link: open-drain clock and data lines
`timescale 1ns/100ps
interface tws_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic scl;
    logic sda;
    // Wired-AND with pull-up: low wins
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));
    modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport host (input scl, input sda, output scl_o, output scl_oe, output sda_host_o, output sda_host_oe);
endinterface : tws_link_if

// File: hw/tws_eeprom_dev.sv
// Device end: two-wire serial memory slave with self-timed write
// Operation
// - Data changes only while clock low
// - Falling data, clock high: start
// - Rising data, clock high: stop
// - Eight-bit words, ack on ninth clock
// - Standby at power-up and after stop
// - Host recovers bus with nine clocks
// - Upper four address bits match type
// - Small variant compares three strap pins
// - Large variant: third bit is page
// - Eighth bit selects read or write
// - Ack match; mismatch returns to standby
// - Byte write: address, word, data, stop
// - Stop starts write; inputs ignored meanwhile
// - Page of 8 or 16 bytes
// - Page write wraps low address bits
// - Polling acked only after write ends
// - Address counter holds last plus one
// - Reads wrap whole memory, writes page
// - Current read: ack, shift byte out
// - Random read: dummy write then read
// - Host ack continues read, wraps end
// - Large variant: nine-bit word address
// - Protect pin blocks upper-half writes
`timescale 1ns/100ps
`include "tws_defines.svh"
module tws_eeprom_dev
    import tws_pkg::*;
#(
    parameter bit LARGE = 1'b1,
    parameter int WR_CYCLES = `TWS_WR_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    tws_link_if.dev link,
    input wire logic strap_select_bit_2,
    input wire logic strap_select_bit_1,
    input wire logic strap_select_bit_0,
    input wire logic write_protect,
    output logic busy
);
    localparam int PB = LARGE ? `TWS_PAGE_BITS_LARGE : `TWS_PAGE_BITS_SMALL;
    localparam int NPAGE = 16;
    localparam int PSIZE = 1 << PB;
    logic [7:0] mem [0:`TWS_MEM_BYTES-1];
    logic [7:0] page_r [0:NPAGE-1];
    logic [NPAGE-1:0] pv_r, pv_nxt;
    logic [2:0] scl_s, sda_s, scl_nxt, sda_nxt;
    logic [3:0] pin_a_r, pin_b_r, pin_a_nxt, pin_b_nxt;
    logic [8:0] cbase;
    logic commit;
    tws_state_e st_r, st_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [8:0] addr_r, addr_nxt;
    logic rd_r, rd_nxt, ackph_r, ackph_nxt, sda_o_r, sda_o_nxt, sda_oe_r, sda_oe_nxt;
    logic [22:0] wcnt_r, wcnt_nxt;
    logic wpend_r, wpend_nxt, busy_nxt;
    logic [3:0] pidx;
    logic rise, fall, start, stop, match, wr_byte, wr_go;
    always_comb begin
        // Synchroniser stage 0 feeds only stage 1
        scl_nxt = {scl_s[1:0], link.scl};
        sda_nxt = {sda_s[1:0], link.sda};
        // Strap and protect pins are board levels, so they pass two stages too
        pin_a_nxt = {write_protect, strap_select_bit_2, strap_select_bit_1, strap_select_bit_0};
        pin_b_nxt = pin_a_r;
    end
    always_ff @(posedge mclk) begin
        scl_s <= scl_nxt;
        sda_s <= sda_nxt;
        pin_a_r <= pin_a_nxt;
        pin_b_r <= pin_b_nxt;
    end
    // Edge and condition detection on synchronised lines
    assign rise = scl_s[1] && !scl_s[2];
    assign fall = !scl_s[1] && scl_s[2];
    assign start = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
    assign stop = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];
    assign match = (sh_r[7:4] == `TWS_DEV_TYPE) && (sh_r[3] == pin_b_r[2])
        && (sh_r[2] == pin_b_r[1]) && (LARGE || sh_r[1] == pin_b_r[0]);
    assign pidx = 4'(addr_r[PB-1:0]);
    assign wr_go = stop && pv_r != '0 && st_r == TWS_WDATA;
    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        addr_nxt = addr_r;
        rd_nxt = rd_r;
        ackph_nxt = ackph_r;
        sda_o_nxt = sda_o_r;
        sda_oe_nxt = sda_oe_r;
        pv_nxt = pv_r;
        wcnt_nxt = wcnt_r;
        wpend_nxt = wpend_r;
        wr_byte = 1'b0;
        if (busy) begin
            // Inputs ignored during self-timed write
            wcnt_nxt = wcnt_r - 23'h1;
            if (wcnt_r == 23'h1) begin
                wpend_nxt = 1'b0;
                pv_nxt = '0;
            end
            st_nxt = TWS_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (start) begin
            st_nxt = TWS_DADDR;
            bit_nxt = 4'h0;
            ackph_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
            pv_nxt = '0;
        end else if (stop) begin
            st_nxt = TWS_IDLE;
            sda_oe_nxt = 1'b0;
            if (wr_go) begin
                wpend_nxt = 1'b1;
                wcnt_nxt = 23'(WR_CYCLES);
            end
        end else if (st_r != TWS_IDLE) begin
            if (rise && !ackph_r) begin
                sh_nxt = {sh_r[6:0], sda_s[1]};
                bit_nxt = bit_r + 4'h1;
            end
            if (rise && ackph_r && st_r == TWS_RACK) begin
                // Host ack continues the read, nack ends it
                if (sda_s[1]) st_nxt = TWS_SKIP;
            end
            if (fall) begin
                if (ackph_r) begin
                    ackph_nxt = 1'b0;
                    sda_oe_nxt = 1'b0;
                    bit_nxt = 4'h0;
                    if (st_r == TWS_RACK) st_nxt = TWS_RDATA;
                    if (st_r == TWS_RDATA || st_r == TWS_RACK) begin
                        // First data bit must stand before the host's first rising clock
                        sda_oe_nxt = 1'b1;
                        sda_o_nxt = mem[LARGE ? addr_r : {1'b0, addr_r[7:0]}][7];
                    end
                end else if (bit_r == 4'h8) begin
                    ackph_nxt = 1'b1;
                    case (st_r)
                        TWS_DADDR: begin
                            if (match) begin
                                sda_oe_nxt = 1'b1;
                                sda_o_nxt = 1'b0;
                                rd_nxt = sh_r[0];
                                if (LARGE) addr_nxt[8] = sh_r[1];
                                st_nxt = sh_r[0] ? TWS_RDATA : TWS_WADDR;
                            end else begin
                                st_nxt = TWS_IDLE;
                            end
                        end
                        TWS_WADDR: begin
                            addr_nxt[7:0] = sh_r;
                            sda_oe_nxt = 1'b1;
                            sda_o_nxt = 1'b0;
                            st_nxt = TWS_WDATA;
                        end
                        TWS_WDATA: begin
                            wr_byte = 1'b1;
                            pv_nxt[pidx] = 1'b1;
                            addr_nxt[PB-1:0] = addr_r[PB-1:0] + 1'b1;
                            sda_oe_nxt = 1'b1;
                            sda_o_nxt = 1'b0;
                        end
                        TWS_RDATA: begin
                            // Release line so host may ack
                            sda_oe_nxt = 1'b0;
                            addr_nxt = LARGE ? addr_r + 9'h1 : {1'b0, addr_r[7:0] + 8'h1};
                            st_nxt = TWS_RACK;
                        end
                        default: st_nxt = TWS_SKIP;
                    endcase
                end
                if (st_r == TWS_RDATA && !ackph_r && bit_r < 4'h8) begin
                    // Shift out on falling clock, MSB first
                    sda_oe_nxt = 1'b1;
                    sda_o_nxt = mem[LARGE ? addr_r : {1'b0, addr_r[7:0]}][3'(7 - bit_r)];
                end
            end
        end
    end
    assign busy_nxt = wpend_nxt;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= TWS_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            addr_r <= 9'h000;
            rd_r <= 1'b0;
            ackph_r <= 1'b0;
            sda_o_r <= 1'b1;
            sda_oe_r <= 1'b0;
            pv_r <= '0;
            wcnt_r <= 23'h0;
            wpend_r <= 1'b0;
            busy <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            rd_r <= rd_nxt;
            ackph_r <= ackph_nxt;
            sda_o_r <= sda_o_nxt;
            sda_oe_r <= sda_oe_nxt;
            pv_r <= pv_nxt;
            wcnt_r <= wcnt_nxt;
            wpend_r <= wpend_nxt;
            busy <= busy_nxt;
        end
    end
    // Page buffer captures data; cells commit only after stop
    always_ff @(posedge mclk) begin
        if (wr_byte) page_r[pidx] <= sh_r;
    end
    // Commit page at end of write cycle, skipping protected upper half
    assign cbase = LARGE ? addr_r : {1'b0, addr_r[7:0]};
    assign commit = busy && wcnt_r == 23'h1 && !(pin_b_r[3] && (LARGE ? addr_r[8] : addr_r[7]));
    // One writing process per cell, so no cell has two drivers
    genvar g;
    generate
        for (g = 0; g < `TWS_MEM_BYTES; g++) begin : g_commit
            always_ff @(posedge mclk) begin
                if (!sys_rst && commit && pv_r[g % PSIZE] && (9'(g) >> PB) == (cbase >> PB)) begin
                    mem[g] <= page_r[g % PSIZE];
                end
            end
        end
    endgenerate
    assign link.sda_dev_o = sda_o_r;
    assign link.sda_dev_oe = sda_oe_r;
endmodule : tws_eeprom_dev

// File: hw/tws_eeprom_host.sv
// Host end: two-wire master that sends or reads bytes on command
`timescale 1ns/100ps
`include "tws_defines.svh"
module tws_eeprom_host
    import tws_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    tws_link_if.host link,
    input wire logic cmd_valid,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire logic cmd_read,
    input wire logic cmd_ack,
    input wire logic [7:0] cmd_data,
    output logic cmd_done,
    output logic [7:0] rsp_data,
    output logic rsp_nack
);
    tws_host_e st_r, st_nxt;
    logic [7:0] div_r, div_nxt, sh_r, sh_nxt, rd_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic scl_r, scl_nxt, sda_r, sda_nxt, stop_r, stop_nxt, rdm_r, rdm_nxt, ack_r, ack_nxt;
    logic done_nxt, nack_nxt;
    logic [1:0] sda_s, sda_snxt;
    logic tick;
    assign tick = div_r == 8'h0;
    assign sda_snxt = {sda_s[0], link.sda};
    always_comb begin
        div_nxt = tick ? `TWS_SCL_HALF : div_r - 8'h1;
        st_nxt = st_r;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        ph_nxt = ph_r;
        scl_nxt = scl_r;
        sda_nxt = sda_r;
        stop_nxt = stop_r;
        rdm_nxt = rdm_r;
        ack_nxt = ack_r;
        done_nxt = 1'b0;
        nack_nxt = rsp_nack;
        rd_nxt = rsp_data;
        case (st_r)
            TWH_IDLE: if (cmd_valid) begin
                sh_nxt = cmd_data;
                stop_nxt = cmd_stop;
                rdm_nxt = cmd_read;
                ack_nxt = cmd_ack;
                bit_nxt = 4'h0;
                ph_nxt = 2'h0;
                st_nxt = cmd_start ? TWH_START : TWH_BIT;
            end
            TWH_START: if (tick) begin
                // Release data, raise clock, then pull data low while clock high
                ph_nxt = ph_r + 2'h1;
                case (ph_r)
                    2'h0: sda_nxt = 1'b1;
                    2'h1: scl_nxt = 1'b1;
                    2'h2: sda_nxt = 1'b0;
                    default: begin
                        scl_nxt = 1'b0;
                        ph_nxt = 2'h0;
                        st_nxt = TWH_BIT;
                    end
                endcase
            end
            TWH_BIT: if (tick) begin
                if (!scl_r) begin
                    // Data is set in the same tick that raises the clock
                    if (bit_r == 4'h8) sda_nxt = rdm_r ? !ack_r : 1'b1;
                    else sda_nxt = rdm_r ? 1'b1 : sh_r[7];
                    scl_nxt = 1'b1;
                end else begin
                    scl_nxt = 1'b0;
                    if (bit_r == 4'h8) begin
                        nack_nxt = sda_s[1];
                        st_nxt = stop_r ? TWH_STOP : TWH_DONE;
                    end else begin
                        sh_nxt = {sh_r[6:0], sda_s[1]};
                        bit_nxt = bit_r + 4'h1;
                        if (bit_r == 4'h7 && rdm_r) rd_nxt = {sh_r[6:0], sda_s[1]};
                    end
                end
            end
            TWH_STOP: if (tick) begin
                ph_nxt = ph_r + 2'h1;
                case (ph_r)
                    2'h0: sda_nxt = 1'b0;
                    2'h1: scl_nxt = 1'b1;
                    default: begin
                        sda_nxt = 1'b1;
                        st_nxt = TWH_DONE;
                    end
                endcase
            end
            TWH_DONE: begin
                done_nxt = 1'b1;
                st_nxt = TWH_IDLE;
            end
            default: st_nxt = TWH_IDLE;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= TWH_IDLE;
            div_r <= 8'h0;
            sh_r <= 8'h0;
            bit_r <= 4'h0;
            ph_r <= 2'h0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            stop_r <= 1'b0;
            rdm_r <= 1'b0;
            ack_r <= 1'b0;
            cmd_done <= 1'b0;
            rsp_nack <= 1'b0;
            rsp_data <= 8'h0;
            sda_s <= 2'b11;
        end else begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            ph_r <= ph_nxt;
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
            stop_r <= stop_nxt;
            rdm_r <= rdm_nxt;
            ack_r <= ack_nxt;
            cmd_done <= done_nxt;
            rsp_nack <= nack_nxt;
            rsp_data <= rd_nxt;
            sda_s <= sda_snxt;
        end
    end
    // Open drain: drive only lows
    assign link.scl_o = 1'b0;
    assign link.scl_oe = !scl_r;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = !sda_r;
endmodule : tws_eeprom_host

// File: bench/tws_link_properties.sv
// Concurrent checks on the link between the host end and the memory end
`timescale 1ns/100ps
module tws_link_properties #(
    parameter int WR_CYCLES = 300
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic busy
);
    logic dev_low;
    logic [15:0] busy_cnt_r;
    logic [15:0] busy_cnt_nxt;
    // Device pulls low; driving high equals release on a wired-AND line
    assign dev_low = sda_dev_oe && !sda_dev_o;
    // Busy span counter, cleared whenever busy drops
    always_comb begin
        busy_cnt_nxt = busy ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge mclk) begin
        busy_cnt_r <= sys_rst ? 16'h0000 : busy_cnt_nxt;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence scl_high_held;
        scl && $past(scl);
    endsequence
    sequence dev_ack_begins;
        $rose(dev_low);
    endsequence
    a_dev_quiet_high: assert property (scl_high_held |-> $stable(dev_low))
        else $error("device data moved while clock high");
    a_no_dev_start: assert property ((scl_high_held and $fell(sda)) |-> !dev_low)
        else $error("device made a start");
    a_no_dev_stop: assert property ((scl_high_held and $rose(sda)) |-> !$past(dev_low))
        else $error("device made a stop");
    a_ack_scl_low: assert property (dev_ack_begins |-> !scl)
        else $error("device drive began with clock high");
    a_ack_held: assert property (dev_ack_begins |-> dev_low[*8])
        else $error("device drive too short");
    a_busy_quiet: assert property (busy |-> !dev_low)
        else $error("device drove line while busy");
    a_busy_after_stop: assert property ($rose(busy) |-> scl && sda)
        else $error("busy without stop");
    a_busy_bounded: assert property (busy |-> busy_cnt_r < WR_CYCLES + 4)
        else $error("write cycle too long");
    a_busy_full_span: assert property ($fell(busy) |-> busy_cnt_r >= WR_CYCLES - 2)
        else $error("write cycle too short");
    a_reset_standby: assert property (disable iff (1'b0) sys_rst |=> !dev_low && !busy)
        else $error("device not in standby after reset");
    a_scl_high_span: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high phase too short");
    a_host_start_clear: assert property ((scl_high_held and $rose(sda_host_oe)) |-> $past(sda))
        else $error("start made on a low data line");
endmodule : tws_link_properties

// File: bench/two_wire_serial_eeprom_access_tb_top.sv
// Self-checking bench: host end drives the memory end across the link
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module two_wire_serial_eeprom_access_tb_top;
    localparam int WR_CYC = 300;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic strap_select_bit_2 = 1'b1;
    logic strap_select_bit_1 = 1'b0;
    logic strap_select_bit_0 = 1'b0;
    logic write_protect = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_start = 1'b0;
    logic cmd_stop = 1'b0;
    logic cmd_read = 1'b0;
    logic cmd_ack = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic busy;
    logic cmd_done;
    logic [7:0] rsp_data;
    logic rsp_nack;
    logic [7:0] mem [512];
    logic [7:0] bad [3] = '{8'hb8, 8'ha0, 8'hac};
    int n_mismatch = 0;
    int n_compared = 0;
    int addr_cnt = 0;
    int n_poll = 0;
    tws_link_if link ();
    always #2.5 mclk = ~mclk;
    tws_eeprom_dev #(.LARGE(1'b1), .WR_CYCLES(WR_CYC)) tws_eeprom_dev_inst (.mclk(mclk), .sys_rst(sys_rst),
        .link(link), .strap_select_bit_2(strap_select_bit_2), .strap_select_bit_1(strap_select_bit_1),
        .strap_select_bit_0(strap_select_bit_0), .write_protect(write_protect), .busy(busy));
    tws_eeprom_host tws_eeprom_host_inst (.mclk(mclk), .sys_rst(sys_rst), .link(link), .cmd_valid(cmd_valid),
        .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_ack(cmd_ack),
        .cmd_data(cmd_data), .cmd_done(cmd_done), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
    tws_link_properties #(.WR_CYCLES(WR_CYC)) tws_link_properties_inst (.mclk(mclk), .sys_rst(sys_rst),
        .scl(link.scl), .sda(link.sda), .scl_o(link.scl_o), .scl_oe(link.scl_oe), .sda_dev_o(link.sda_dev_o),
        .sda_dev_oe(link.sda_dev_oe), .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe), .busy(busy));
    // Address word: type code, straps, page bit, direction
    function automatic logic [7:0] dev_word(input logic [8:0] a, input logic rd);
        return {4'ha, strap_select_bit_2, strap_select_bit_1, a[8], rd};
    endfunction : dev_word
    // One host command; entered and left at a falling edge
    task automatic cmd(input logic st, input logic sp, input logic rd, input logic ak, input logic [7:0] d);
        int k;
        {cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_data} = {st, sp, rd, ak, d};
        cmd_valid = 1'b1;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (cmd_done !== 1'b1 && k < 2000);
        cmd_valid = 1'b0;
        if (k >= 2000) n_mismatch++;
        @(negedge mclk);
    endtask : cmd
    // Polls until acknowledged, then loads the word address
    task automatic load_addr(input logic [8:0] a);
        n_poll = 0;
        strap_select_bit_0 = 1'($urandom);
        cmd(1'b1, 1'b0, 1'b0, 1'b0, dev_word(a, 1'b0));
        while (rsp_nack !== 1'b0 && n_poll < 20) begin
            n_poll++;
            cmd(1'b1, 1'b0, 1'b0, 1'b0, dev_word(a, 1'b0));
        end
        cmd(1'b0, 1'b0, 1'b0, 1'b0, a[7:0]);
        `CHK("word address ack", 1'b0, rsp_nack)
    endtask : load_addr
    task automatic wr_seq(input logic [8:0] a, input int n);
        logic [7:0] d;
        load_addr(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            cmd(1'b0, i == n - 1, 1'b0, 1'b0, d);
            `CHK("data ack", 1'b0, rsp_nack)
            // Protected upper half keeps old data; low bits wrap in the page
            if (!(write_protect && a[8])) mem[{a[8:4], a[3:0] + 4'(i)}] = d;
        end
    endtask : wr_seq
    task automatic cur_rd(input int n);
        cmd(1'b1, 1'b0, 1'b0, 1'b0, dev_word(9'(addr_cnt), 1'b1));
        `CHK("read address ack", 1'b0, rsp_nack)
        for (int i = 0; i < n; i++) begin
            cmd(1'b0, i == n - 1, 1'b1, i != n - 1, 8'h00);
            `CHK("read data", mem[addr_cnt], rsp_data)
            addr_cnt = (addr_cnt + 1) % 512;
        end
    endtask : cur_rd
    // Dummy write loads the counter, repeated start turns it into a read
    task automatic rd_seq(input logic [8:0] a, input int n, input logic exp_busy);
        load_addr(a);
        `CHK("poll refused", exp_busy, n_poll > 0)
        addr_cnt = a;
        cur_rd(n);
    endtask : rd_seq
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    // Main sequence
    initial begin
        void'($urandom(97667));
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        repeat (4) @(negedge mclk);
        foreach (bad[j]) begin
            cmd(1'b1, 1'b1, 1'b0, 1'b0, bad[j]);
            `CHK("refused address", 1'b1, rsp_nack)
        end
        $display("test refused_address done");
        wr_seq(9'h1f3, 18);
        wr_seq(9'h000, 6);
        rd_seq(9'h1fe, 4, 1'b1);
        cur_rd(1);
        // Read cut with no stop; nine released clocks free the line before the next start
        cmd(1'b1, 1'b0, 1'b0, 1'b0, dev_word(9'(addr_cnt), 1'b1));
        `CHK("cut read ack", 1'b0, rsp_nack)
        cmd(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
        `CHK("cut read", mem[addr_cnt], rsp_data)
        cmd(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        `CHK("recovery line high", 1'b1, rsp_nack)
        `CHK("recovery read", mem[(addr_cnt + 1) % 512], rsp_data)
        addr_cnt = (addr_cnt + 2) % 512;
        $display("test page_wrap_read done");
        write_protect = 1'b1;
        wr_seq(9'h1f8, 2);
        wr_seq(9'h010, 3);
        write_protect = 1'b0;
        rd_seq(9'h1f6, 4, 1'b1);
        rd_seq(9'h010, 3, 1'b0);
        $display("test write_protect done");
        test_done();
    end
    // Watchdog: a few dozen transfers of some hundred cycles each fit well inside
    initial begin
        #400000;
        n_mismatch++;
        test_done();
    end
endmodule : two_wire_serial_eeprom_access_tb_top
